// File: src/ptpc_timer.sv
// Purpose: 10-bit periodic timer with compare, PWM, single pulse and capture modes
// Assumes: control bits are plain ports; software writes reach the run bit and compare A as strobes
// Notes:   counter advances on a divided timer tick; pins pass a three-flop filter

`timescale 1ns/100ps

module ptpc_timer (
  input  wire logic                 clk_sys,           // system clock, 25 MHz
  input  wire logic                 rst_n,             // synchronous reset, active low
  input  wire ptpc_pkg::ptpc_ctrl_t ctrl,              // mode and control bits
  input  wire logic                 runWrite,          // software write strobe to run bit
  input  wire logic                 runWriteData,      // value written to run bit
  input  wire logic                 compareAWrite,     // software write strobe to compare A
  input  wire logic [9:0]           compareAWriteData, // value written to compare A
  input  wire logic [9:0]           compareP,          // compare P value
  input  wire logic [1:0]           timerExtPin,       // external timer pins
  output ptpc_pkg::ptpc_status_t    status,            // counter, compare A, run bit
  output logic                      timerOutPin,       // timer output pin level
  output logic                      timerOutEnable,    // high while the output pin is driven
  output logic                      irqCompareA,       // pulse: compare A match or capture
  output logic                      irqCompareP        // pulse: compare P match
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function automatic logic [9:0] incCount(input logic [9:0] value);
    incCount = value + ptpc_pkg::CNT_ONE;
  endfunction

  function automatic logic isMatch(input logic [9:0] nextValue, input logic [9:0] target);
    isMatch = (nextValue == target);
  endfunction

  // --------------------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------------------
  logic [5:0] divCount;
  logic [5:0] divLimit;
  logic       tick;
  logic [1:0] pinRise;
  logic [1:0] pinFall;
  logic       selRise;
  logic       selFall;
  logic       counterRunBit;
  logic       runPrev;
  logic       runRise;
  logic [9:0] counter;
  logic [9:0] compareAValue;
  logic [9:0] next_count;
  logic       countStep;
  logic       hitA;
  logic       hitP;
  logic       aNonZero;
  logic       pNonZero;
  logic       isCompare;
  logic       isCapture;
  logic       isPwm;
  logic       isSinglePulse;
  logic       clearHit;
  logic       edgeHit;
  logic       captureHit;
  logic       pulseSet;
  logic       pulseStop;
  logic       outState;
  logic       waveActive;
  logic       pinDriven;

  // --------------------------------------------------------------------------
  // timer clock divider
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (ctrl.clockDivSelect)
      2'h0: divLimit = ptpc_pkg::DIV_TC_1;
      2'h1: divLimit = ptpc_pkg::DIV_TC_4;
      2'h2: divLimit = ptpc_pkg::DIV_TC_16;
      2'h3: divLimit = ptpc_pkg::DIV_TC_64;
    endcase
  end

  // >= so a smaller divide chosen mid-count cannot strand the counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      divCount <= ptpc_pkg::DIV_RESET;
    end else if (divCount >= divLimit) begin
      divCount <= ptpc_pkg::DIV_RESET;
    end else begin
      divCount <= divCount + 6'h01;
    end
  end

  assign tick = (divCount >= divLimit);

  // --------------------------------------------------------------------------
  // external pins
  // --------------------------------------------------------------------------
  // both filtered, a source switch finds settled levels
  for (genvar i = 0; i < 2; i++) begin : g_pin
    ptpc_pin_sync u_sync (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .pinIn    (timerExtPin[i]),
      .pinLevel (),
      .pinRise  (pinRise[i]),
      .pinFall  (pinFall[i])
    );
  end

  // --------------------------------------------------------------------------
  // capture source
  // --------------------------------------------------------------------------
  // pin is sampled whatever its direction, so own output edges can capture
  assign selRise = pinRise[ctrl.captureSourceSelect];
  assign selFall = pinFall[ctrl.captureSourceSelect];

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  // timer mode is compare with the pin released
  always_comb begin
    isCompare     = 1'b0;
    isCapture     = 1'b0;
    isPwm         = 1'b0;
    isSinglePulse = 1'b0;
    unique case (ctrl.modeSelect)
      ptpc_pkg::PTPC_MODE_COMPARE: isCompare = 1'b1;
      ptpc_pkg::PTPC_MODE_TIMER:   isCompare = 1'b1;
      ptpc_pkg::PTPC_MODE_CAPTURE: isCapture = 1'b1;
      ptpc_pkg::PTPC_MODE_PWM: begin
        isSinglePulse = (ctrl.ioControlField == ptpc_pkg::IO_SINGLE_PULSE);
        isPwm         = (ctrl.ioControlField != ptpc_pkg::IO_SINGLE_PULSE);
      end
    endcase
  end

  // --------------------------------------------------------------------------
  // match detection
  // --------------------------------------------------------------------------
  assign runRise    = counterRunBit && !runPrev;
  assign countStep  = counterRunBit && tick && !runRise;
  assign next_count = incCount(counter);
  assign aNonZero   = (compareAValue != ptpc_pkg::CNT_ZERO);
  assign pNonZero   = (compareP != ptpc_pkg::CNT_ZERO);
  // next value compared: event and load share one tick
  assign hitA       = countStep && isMatch(next_count, compareAValue);
  // a zero compare P never matches, the counter wraps through 3FF instead
  assign hitP       = countStep && pNonZero && isMatch(next_count, compareP);

  always_comb begin
    clearHit = 1'b0;
    if (isCompare) begin
      clearHit = ctrl.counterClearSelect ? (hitA && aNonZero) : hitP;
    end else if (isCapture || isPwm) begin
      clearHit = hitP;
    end
  end

  // --------------------------------------------------------------------------
  // capture edge select
  // --------------------------------------------------------------------------
  always_comb begin
    unique case (ctrl.ioControlField)
      ptpc_pkg::IO_CAP_RISE: edgeHit = selRise;
      ptpc_pkg::IO_CAP_FALL: edgeHit = selFall;
      ptpc_pkg::IO_CAP_BOTH: edgeHit = selRise || selFall;
      ptpc_pkg::IO_CAP_NONE: edgeHit = 1'b0;
    endcase
  end

  assign captureHit = isCapture && counterRunBit && edgeHit;

  // --------------------------------------------------------------------------
  // run bit
  // --------------------------------------------------------------------------
  assign pulseSet  = isSinglePulse && selRise;
  assign pulseStop = isSinglePulse && hitA;

  // pin set beats a same-cycle software clear so no trigger is lost
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      counterRunBit <= 1'b0;
    end else if (pulseSet) begin
      counterRunBit <= 1'b1;
    end else if (runWrite) begin
      counterRunBit <= runWriteData;
    end else if (pulseStop) begin
      counterRunBit <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // run edge tracking
  // --------------------------------------------------------------------------
  // edge seen one clock late: a clean zero cycle
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      runPrev <= 1'b0;
    end else begin
      runPrev <= counterRunBit;
    end
  end

  // --------------------------------------------------------------------------
  // counter
  // --------------------------------------------------------------------------
  // single pulse never clears here: it stops with the run bit and holds
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      counter <= ptpc_pkg::CNT_ZERO;
    end else if (runRise) begin
      counter <= ptpc_pkg::CNT_ZERO;
    end else if (countStep) begin
      if (clearHit && !isSinglePulse) begin
        counter <= ptpc_pkg::CNT_ZERO;
      end else begin
        counter <= next_count;
      end
    end
  end

  // --------------------------------------------------------------------------
  // compare A register
  // --------------------------------------------------------------------------
  // capture wins over a same-cycle software write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      compareAValue <= ptpc_pkg::CMPA_RESET;
    end else if (captureHit) begin
      compareAValue <= counter;
    end else if (compareAWrite) begin
      compareAValue <= compareAWriteData;
    end
  end

  // --------------------------------------------------------------------------
  // interrupt pulses
  // --------------------------------------------------------------------------
  // pulses only; the flag owner latches them
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      irqCompareA <= 1'b0;
      irqCompareP <= 1'b0;
    end else begin
      irqCompareA <= (isSinglePulse && hitA)
                   || (isPwm && hitA)
                   || (isCompare && hitA && aNonZero)
                   || captureHit;
      irqCompareP <= (isCapture && hitP)
                   || (isPwm && hitP)
                   || (isCompare && hitP && !ctrl.counterClearSelect);
    end
  end

  // --------------------------------------------------------------------------
  // compare mode output state
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      outState <= 1'b0;
    end else if (runRise) begin
      outState <= 1'b0;
    end else if (isCompare && hitA && aNonZero) begin
      unique case (ctrl.ioControlField)
        ptpc_pkg::IO_CMP_NONE:     outState <= outState;
        ptpc_pkg::IO_CMP_INACTIVE: outState <= 1'b0;
        ptpc_pkg::IO_CMP_ACTIVE:   outState <= 1'b1;
        ptpc_pkg::IO_CMP_TOGGLE:   outState <= !outState;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // output waveform
  // --------------------------------------------------------------------------
  // counter keeps running under forced levels, so releasing keeps the period
  always_comb begin
    waveActive = 1'b0;
    if (isSinglePulse) begin
      waveActive = counterRunBit && !runRise ? 1'b1 : counterRunBit;
    end else if (isPwm) begin
      unique case (ctrl.ioControlField)
        ptpc_pkg::IO_PWM_FORCE_LO: waveActive = 1'b0;
        ptpc_pkg::IO_PWM_FORCE_HI: waveActive = 1'b1;
        ptpc_pkg::IO_PWM_WAVE:     waveActive = counterRunBit && !runRise && (counter < compareAValue);
        ptpc_pkg::IO_SINGLE_PULSE: waveActive = 1'b0;
      endcase
    end else if (isCompare) begin
      waveActive = outState;
    end
  end

  // capture and timer modes have no output function
  assign pinDriven = isSinglePulse || isPwm || (ctrl.modeSelect == ptpc_pkg::PTPC_MODE_COMPARE);

  // --------------------------------------------------------------------------
  // output pin register
  // --------------------------------------------------------------------------
  // registered so mode changes never glitch the pin
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      timerOutPin    <= 1'b0;
      timerOutEnable <= 1'b0;
    end else begin
      timerOutEnable <= pinDriven;
      if (pinDriven) begin
        timerOutPin <= (waveActive ? ctrl.outputControlBit : !ctrl.outputControlBit)
                       ^ ctrl.outputPolarityBit;
      end else begin
        timerOutPin <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // status
  // --------------------------------------------------------------------------
  assign status.counterValue  = counter;
  assign status.compareAValue = compareAValue;
  assign status.counterRunBit = counterRunBit;

endmodule

// File: src/ptpc_pkg.sv
// Purpose: shared constants and carrier types of the periodic timer, pulse and capture unit
// Assumes: one system clock, synchronous active-low reset
// Notes:   every offset-free field and count used by more than one file lives here

package ptpc_pkg;

  // --------------------------------------------------------------------------
  // counter geometry
  // --------------------------------------------------------------------------
  localparam int         CNT_W      = 10;
  localparam logic [9:0] CNT_MAX    = 10'h3FF;
  localparam logic [9:0] CNT_ZERO   = 10'h000;
  localparam logic [9:0] CNT_ONE    = 10'h001;
  localparam logic [9:0] CMPA_RESET = 10'h000;

  // --------------------------------------------------------------------------
  // operating modes, coded as mode_select_hi:mode_select_lo
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    PTPC_MODE_COMPARE = 2'b00,
    PTPC_MODE_CAPTURE = 2'b01,
    PTPC_MODE_PWM     = 2'b10,
    PTPC_MODE_TIMER   = 2'b11
  } ptpc_mode_t;

  // --------------------------------------------------------------------------
  // io control field codes, meaning depends on mode
  // --------------------------------------------------------------------------
  localparam logic [1:0] IO_CMP_NONE     = 2'h0;
  localparam logic [1:0] IO_CMP_INACTIVE = 2'h1;
  localparam logic [1:0] IO_CMP_ACTIVE   = 2'h2;
  localparam logic [1:0] IO_CMP_TOGGLE   = 2'h3;
  localparam logic [1:0] IO_PWM_FORCE_LO = 2'h0;
  localparam logic [1:0] IO_PWM_FORCE_HI = 2'h1;
  localparam logic [1:0] IO_PWM_WAVE     = 2'h2;
  localparam logic [1:0] IO_SINGLE_PULSE = 2'h3;
  localparam logic [1:0] IO_CAP_RISE     = 2'h0;
  localparam logic [1:0] IO_CAP_FALL     = 2'h1;
  localparam logic [1:0] IO_CAP_BOTH     = 2'h2;
  localparam logic [1:0] IO_CAP_NONE     = 2'h3;

  // --------------------------------------------------------------------------
  // timer clock divider: terminal counts for divide by 1, 4, 16, 64
  // --------------------------------------------------------------------------
  localparam logic [5:0] DIV_RESET = 6'h00;
  localparam logic [5:0] DIV_TC_1  = 6'h00;
  localparam logic [5:0] DIV_TC_4  = 6'h03;
  localparam logic [5:0] DIV_TC_16 = 6'h0F;
  localparam logic [5:0] DIV_TC_64 = 6'h3F;

  // --------------------------------------------------------------------------
  // carriers
  // --------------------------------------------------------------------------
  typedef struct packed {
    ptpc_mode_t modeSelect;          // mode_select_hi, mode_select_lo
    logic [1:0] ioControlField;      // io_control_hi, io_control_lo
    logic       outputControlBit;    // active level of the output
    logic       outputPolarityBit;   // inverts the output pin
    logic       counterClearSelect;  // compare mode: clear on A instead of P
    logic       captureSourceSelect; // picks one of two external pins
    logic [1:0] clockDivSelect;      // timer clock divide 1/4/16/64
  } ptpc_ctrl_t;

  typedef struct packed {
    logic [9:0] counterValue;
    logic [9:0] compareAValue;
    logic       counterRunBit;
  } ptpc_status_t;

endpackage

// File: src/ptpc_pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter and edge pulses
// Assumes: pinIn is asynchronous to clk_sys
// Notes:   a change counts once stages two and three agree

`timescale 1ns/100ps

module ptpc_pin_sync (
  input  wire logic clk_sys,  // system clock
  input  wire logic rst_n,    // synchronous reset, active low
  input  wire logic pinIn,    // raw external pin
  output logic      pinLevel, // filtered level
  output logic      pinRise,  // one-cycle pulse on accepted rise
  output logic      pinFall   // one-cycle pulse on accepted fall
);

  logic syncA;
  logic syncB;
  logic syncC;
  logic agree;

  // --------------------------------------------------------------------------
  // synchroniser chain and filtered level
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      syncA    <= 1'b0;
      syncB    <= 1'b0;
      syncC    <= 1'b0;
      pinLevel <= 1'b0;
    end else begin
      syncA <= pinIn;
      syncB <= syncA;
      syncC <= syncB;
      if (agree) begin
        pinLevel <= syncC;
      end
    end
  end

  // first stage is read only by the second
  assign agree   = (syncB == syncC);
  assign pinRise = agree && syncC && !pinLevel;
  assign pinFall = agree && !syncC && pinLevel;

endmodule

// File: tb/ptpc_timer_checker.sv
// Purpose: port-level assertions for the periodic timer
// Assumes: bound to ptpc_timer, one clock domain
// Notes:   single pulse is mode 10 with io 11
`timescale 1ns/100ps

module ptpc_timer_checker (
  input wire logic                   clk_sys,           // system clock
  input wire logic                   rst_n,             // reset, active low
  input wire ptpc_pkg::ptpc_ctrl_t   ctrl,              // control bits
  input wire logic                   runWrite,          // run write strobe
  input wire logic                   runWriteData,      // run write value
  input wire logic                   compareAWrite,     // compare A write strobe
  input wire logic [9:0]             compareAWriteData, // compare A write value
  input wire logic [9:0]             compareP,          // compare P value
  input wire logic [1:0]             timerExtPin,       // external pins
  input wire ptpc_pkg::ptpc_status_t status,            // counter, compare A, run
  input wire logic                   timerOutPin,       // output pin
  input wire logic                   timerOutEnable,    // output enable
  input wire logic                   irqCompareA,       // compare A event
  input wire logic                   irqCompareP        // compare P event
);
  logic sp;
  logic cap;
  assign sp  = ctrl.modeSelect == ptpc_pkg::PTPC_MODE_PWM && ctrl.ioControlField == ptpc_pkg::IO_SINGLE_PULSE;
  assign cap = ctrl.modeSelect == ptpc_pkg::PTPC_MODE_CAPTURE;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_run_write_set: assert property (runWrite && runWriteData |=> status.counterRunBit)
    else $error("run bit not set by write");
  a_idle_count_hold: assert property (!status.counterRunBit |=> $stable(status.counterValue))
    else $error("counter moved while stopped");
  a_idle_irq_quiet: assert property (!status.counterRunBit [*3] |-> !irqCompareA && !irqCompareP)
    else $error("event while stopped");
  a_rise_zero_count: assert property ($rose(status.counterRunBit) |=> status.counterValue == ptpc_pkg::CNT_ZERO)
    else $error("counter not zeroed on start");
  a_pulse_stop_a: assert property (sp && $fell(status.counterRunBit) && !$past(runWrite)
    |-> status.counterValue == status.compareAValue ##[0:1] irqCompareA)
    else $error("pulse did not end on compare A");
  a_pulse_pin_level: assert property (sp && $past(rst_n) && $stable(ctrl) ##1 $stable(ctrl) |-> timerOutEnable
    && timerOutPin == (($past(status.counterRunBit) ? ctrl.outputControlBit : !ctrl.outputControlBit)
    ^ ctrl.outputPolarityBit))
    else $error("pulse pin level wrong");
  a_capture_irq_sent: assert property (cap && $changed(status.compareAValue) && !$past(compareAWrite)
    |-> ##[0:1] irqCompareA)
    else $error("capture without event");
  a_capture_none_held: assert property (cap && ctrl.ioControlField == ptpc_pkg::IO_CAP_NONE && $stable(ctrl)
    && !compareAWrite |=> $stable(status.compareAValue))
    else $error("capture with io 11");
  a_capture_no_output: assert property (cap && $stable(ctrl) |=> !timerOutEnable && !timerOutPin)
    else $error("output driven in capture mode");
  a_p_bound_count: assert property (cap && compareP != 10'h000 && $stable(compareP) && status.counterRunBit
    && $past(status.counterRunBit) |-> status.counterValue < compareP)
    else $error("counter passed compare P");
endmodule

bind ptpc_timer ptpc_timer_checker ptpc_timer_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl),
  .runWrite(runWrite), .runWriteData(runWriteData), .compareAWrite(compareAWrite),
  .compareAWriteData(compareAWriteData), .compareP(compareP), .timerExtPin(timerExtPin), .status(status),
  .timerOutPin(timerOutPin), .timerOutEnable(timerOutEnable), .irqCompareA(irqCompareA),
  .irqCompareP(irqCompareP));

// File: tb/ptpc_pin_source.sv
// Purpose: external source on the two timer pins
// Assumes: pins are plain levels with no pull
// Notes:   each change is held so the three-flop filter accepts it
`timescale 1ns/100ps

module ptpc_pin_source (
  input  wire logic       clk_sys, // system clock
  output logic      [1:0] extPin   // external timer pin levels
);
  initial extPin = 2'h0;

  task automatic drive(input int idx, input logic level, input int holdCycles);
    @(posedge clk_sys);
    #1;
    extPin[idx] = level;
    repeat (holdCycles) @(posedge clk_sys);
    #1;
  endtask
endmodule

// File: tb/tb_ptpc_timer.sv
// Purpose: self-checking bench for the periodic timer
// Assumes: divide by 1 timer clock
// Notes:   capture timing checked within a window, filter delay not exact
`timescale 1ns/100ps

module tb_ptpc_timer;
  logic                   clk_sys;
  logic                   rst_n;
  ptpc_pkg::ptpc_ctrl_t   ctrl;
  logic                   runWrite;
  logic                   runWriteData;
  logic                   compareAWrite;
  logic [9:0]             compareAWriteData;
  logic [9:0]             compareP;
  logic [1:0]             timerExtPin;
  ptpc_pkg::ptpc_status_t status;
  logic                   timerOutPin;
  logic                   timerOutEnable;
  logic                   irqCompareA;
  logic                   irqCompareP;
  int                     fails = 0;
  int                     comparisons = 0;
  int                     irqACount = 0;
  int                     irqPCount = 0;

  ptpc_timer ptpc_timer_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl(ctrl), .runWrite(runWrite),
    .runWriteData(runWriteData), .compareAWrite(compareAWrite), .compareAWriteData(compareAWriteData),
    .compareP(compareP), .timerExtPin(timerExtPin), .status(status), .timerOutPin(timerOutPin),
    .timerOutEnable(timerOutEnable), .irqCompareA(irqCompareA), .irqCompareP(irqCompareP));
  ptpc_pin_source ptpc_pin_source_inst (.clk_sys(clk_sys), .extPin(timerExtPin));

  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (irqCompareA === 1'b1) irqACount++;
    if (irqCompareP === 1'b1) irqPCount++;
  end

  task automatic final_report;
    if (fails == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [9:0] expv, input logic [9:0] gotv);
    comparisons++;
    if (gotv !== expv) begin
      fails++;
      $display("unexpected %s expected %h seen %h", name, expv, gotv);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic writeRun(input logic v);
    runWrite = 1'b1;
    runWriteData = v;
    cyc(1);
    runWrite = 1'b0;
    cyc(1);
  endtask

  task automatic writeA(input logic [9:0] v);
    compareAWrite = 1'b1;
    compareAWriteData = v;
    cyc(1);
    compareAWrite = 1'b0;
    cyc(1);
  endtask

  task automatic waitRun(input logic lvl, input int limit);
    int r;
    r = 0;
    while (status.counterRunBit !== lvl && r < limit) begin
      cyc(1);
      r++;
    end
    check("run bit", {9'h0, lvl}, {9'h0, status.counterRunBit});
  endtask

  function automatic logic capExp(input logic [1:0] io, input logic rising);
    return io == ptpc_pkg::IO_CAP_BOTH || (io == ptpc_pkg::IO_CAP_RISE && rising)
      || (io == ptpc_pkg::IO_CAP_FALL && !rising);
  endfunction

  initial begin
    #800000;
    fails++;
    final_report();
  end

  initial begin
    int a, k, io, n0, idx;
    logic [9:0] prevA, cnt, diff, mx;
    rst_n = 1'b0;
    ctrl = '0;
    runWrite = 1'b0;
    runWriteData = 1'b0;
    compareAWrite = 1'b0;
    compareAWriteData = 10'h000;
    compareP = 10'h000;
    void'($urandom(32'h370774f7));
    cyc(2);
    rst_n = 1'b1;
    cyc(1);
    // ----------------------------------------------------------------------
    // single pulse: width set by compare A, P and clear select random
    // ----------------------------------------------------------------------
    for (k = 0; k < 4; k++) begin
      ctrl = {ptpc_pkg::PTPC_MODE_PWM, ptpc_pkg::IO_SINGLE_PULSE, 1'($urandom), 1'($urandom), 1'($urandom),
        1'b0, 2'h0};
      compareP = 10'($urandom);
      a = (k == 0) ? 1 : 2 + $urandom % 40;
      writeA(10'(a));
      n0 = irqACount;
      if (k == 3) ptpc_pin_source_inst.drive(0, 1'b1, 2);
      else writeRun(1'b1);
      waitRun(1'b1, 20);
      cyc(1);
      check("pulse lead pin", {9'h0, ctrl.outputControlBit ^ ctrl.outputPolarityBit}, {9'h0, timerOutPin});
      check("pulse pin enable", 10'h001, {9'h0, timerOutEnable});
      waitRun(1'b0, 100);
      cyc(3);
      check("pulse end count", 10'(a), status.counterValue);
      check("pulse event", 10'(n0 + 1), 10'(irqACount));
      check("pulse idle pin", {9'h0, ctrl.outputControlBit ~^ ctrl.outputPolarityBit}, {9'h0, timerOutPin});
      if (k == 3) ptpc_pin_source_inst.drive(0, 1'b0, 4);
    end
    writeA(10'h1F4);
    writeRun(1'b1);
    cyc(10);
    writeRun(1'b0);
    cyc(2);
    check("cleared run", 10'h000, {9'h0, status.counterRunBit});
    check("cleared pin", {9'h0, ctrl.outputControlBit ~^ ctrl.outputPolarityBit}, {9'h0, timerOutPin});
    // ----------------------------------------------------------------------
    // capture: every io code, selected and other pin, both edges
    // ----------------------------------------------------------------------
    ctrl = {ptpc_pkg::PTPC_MODE_CAPTURE, 2'h0, 1'($urandom), 1'($urandom), 1'($urandom), 1'($urandom), 2'h0};
    compareP = 10'h000;
    writeRun(1'b1);
    check("capture pin enable", 10'h000, {9'h0, timerOutEnable});
    for (io = 0; io < 5; io++) begin
      if (io == 4) writeRun(1'b0);
      ctrl.ioControlField = (io == 4) ? ptpc_pkg::IO_CAP_BOTH : 2'(io);
      for (k = 0; k < 4; k++) begin
        idx = (k < 2) ? ctrl.captureSourceSelect : !ctrl.captureSourceSelect;
        prevA = status.compareAValue;
        cnt = status.counterValue;
        ptpc_pin_source_inst.drive(idx, !k[0], 8);
        cyc(1);
        diff = status.compareAValue - cnt;
        if (k < 2 && io < 4 && capExp(2'(io), !k[0])) begin
          check("capture window", 10'h001, {9'h0, diff >= 10'h002 && diff <= 10'h007});
        end else begin
          check("capture held", prevA, status.compareAValue);
        end
      end
    end
    // ----------------------------------------------------------------------
    // compare P bounds the count, zero gives the full range
    // ----------------------------------------------------------------------
    compareP = 10'(5 + $urandom % 20);
    n0 = irqPCount;
    writeRun(1'b1);
    cyc(120);
    check("capture P events", 10'h001, {9'h0, irqPCount >= n0 + 4});
    writeRun(1'b0);
    compareP = 10'h000;
    writeRun(1'b1);
    mx = 10'h000;
    for (k = 0; k < 1100; k++) begin
      cyc(1);
      if (status.counterValue > mx) mx = status.counterValue;
    end
    check("full range max", ptpc_pkg::CNT_MAX, mx);
    writeRun(1'b0);
    // ----------------------------------------------------------------------
    // PWM: forced levels keep the period running
    // ----------------------------------------------------------------------
    for (io = 0; io < 2; io++) begin
      ctrl = {ptpc_pkg::PTPC_MODE_PWM, 2'(io), 1'($urandom), 1'($urandom), 1'($urandom), 1'b0, 2'h0};
      compareP = 10'h008;
      writeA(10'h003);
      n0 = irqPCount;
      writeRun(1'b1);
      cyc(40);
      check("pwm period events", 10'h001, {9'h0, irqPCount >= n0 + 3});
      check("pwm forced pin", {9'h0, (io == 1) ? ctrl.outputControlBit ^ ctrl.outputPolarityBit
        : ctrl.outputControlBit ~^ ctrl.outputPolarityBit}, {9'h0, timerOutPin});
      writeRun(1'b0);
    end
    final_report();
  end
endmodule
